// [src/dms_pkg.sv]
// Package of constants for the DDR3 mode register and init tracker.
package dms_pkg;
	localparam int CMD_W = 4;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_ZQCL = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam int BA_W = 3;
	localparam int MR_W = 16;
	localparam int MR_DLL_RST_BIT = 8;
	localparam logic [MR_W-1:0] MR_RESET_VALUE = 16'h0000;
	localparam int CLK_MHZ = 100;
	localparam int TMOD_CK = 12;
	localparam int TMOD_NS = 15;
	localparam int TMOD_CYC = (TMOD_NS * CLK_MHZ + 999) / 1000 > TMOD_CK ?
		(TMOD_NS * CLK_MHZ + 999) / 1000 : TMOD_CK;
	localparam int TDLLK_CK = 512;
	localparam int TZQINIT_CK = 512;
	localparam int CNT_W = 10;
	typedef enum logic [2:0] {
		DMS_RESET = 3'b000,
		DMS_CKE_LOW = 3'b001,
		DMS_CKE_HIGH = 3'b011,
		DMS_CALIB = 3'b010,
		DMS_READY = 3'b110
	} dms_state_type;
endpackage

// [src/dms_sync.sv]
// Three-stage synchroniser with agreement check for one outside input.
`timescale 1ns/1ns
module dms_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 1'b0;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule

// [src/dms_top.sv]
// DDR3 device side: mode registers, termination gating and init readiness.
`timescale 1ns/1ns
module dms_top
	import dms_pkg::*;
#(
	parameter int TMOD = TMOD_CYC,
	parameter int TDLLK = TDLLK_CK,
	parameter int TZQINIT = TZQINIT_CK
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ck,
	input wire logic dev_reset_n,
	input wire logic cke,
	input wire logic odt,
	input wire logic [CMD_W-1:0] cmd,
	input wire logic [BA_W-1:0] ba,
	input wire logic [MR_W-1:0] addr,
	output logic [MR_W-1:0] mr0,
	output logic [MR_W-1:0] mr1,
	output logic [MR_W-1:0] mr2,
	output logic [MR_W-1:0] mr3,
	output logic term_enable,
	output logic features_valid,
	output logic dll_locked,
	output logic zq_done,
	output logic dev_ready
);
	logic rst_a_q;
	logic rst_n_q;
	logic ck_s;
	logic ck_prev_q;
	logic ck_rise;
	logic devrst_s;
	logic cke_s;
	logic odt_s;
	logic cke_seen_q;
	logic [CNT_W-1:0] mod_cnt_q;
	logic [CNT_W-1:0] dll_cnt_q;
	logic [CNT_W-1:0] zq_cnt_q;
	logic dll_busy_q;
	logic zq_busy_q;
	logic mrs_hit;
	logic zq_hit;
	logic dll_rst_hit;
	dms_state_type state_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	dms_sync u_ck (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(ck), .dout(ck_s));
	dms_sync u_rst (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(dev_reset_n), .dout(devrst_s));
	dms_sync u_cke (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(cke), .dout(cke_s));
	dms_sync u_odt (.clk_sys(clk_sys), .rst_n(rst_n_q), .din(odt), .dout(odt_s));

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ck_prev_q <= 1'b0;
		end else begin
			ck_prev_q <= ck_s;
		end
	end

	assign ck_rise = ck_s && !ck_prev_q;
	assign mrs_hit = ck_rise && devrst_s && cke_s && (cmd == CMD_MRS);
	assign zq_hit = ck_rise && devrst_s && cke_s && (cmd == CMD_ZQCL);
	assign dll_rst_hit = mrs_hit && ba[1:0] == 2'h0 && addr[MR_DLL_RST_BIT];

	// Termination stays off while reset is low, and after reset until CKE is first seen high on a CK rise.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cke_seen_q <= 1'b0;
		end else if (!devrst_s) begin
			cke_seen_q <= 1'b0;
		end else if (ck_rise && cke_s) begin
			cke_seen_q <= 1'b1;
		end
	end

	assign term_enable = cke_seen_q && devrst_s && odt_s && features_valid;

	// Mode registers load on MRS and clear on device reset.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mr0 <= MR_RESET_VALUE;
			mr1 <= MR_RESET_VALUE;
			mr2 <= MR_RESET_VALUE;
			mr3 <= MR_RESET_VALUE;
		end else if (!devrst_s) begin
			mr0 <= MR_RESET_VALUE;
			mr1 <= MR_RESET_VALUE;
			mr2 <= MR_RESET_VALUE;
			mr3 <= MR_RESET_VALUE;
		end else if (mrs_hit) begin
			unique case (ba[1:0])
				2'h0: begin
					mr0 <= addr;
					mr0[MR_DLL_RST_BIT] <= 1'b0;
				end
				2'h1: mr1 <= addr;
				2'h2: mr2 <= addr;
				2'h3: mr3 <= addr;
			endcase
		end
	end

	// Features count as updated only after tMOD clock edges.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mod_cnt_q <= '0;
		end else if (!devrst_s) begin
			mod_cnt_q <= '0;
		end else if (mrs_hit) begin
			mod_cnt_q <= CNT_W'(TMOD);
		end else if (ck_rise && mod_cnt_q != '0) begin
			mod_cnt_q <= mod_cnt_q - 1'b1;
		end
	end

	assign features_valid = (mod_cnt_q == '0);

	// DLL lock timer, started by an MRS to MR0 with the reset bit set.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dll_cnt_q <= '0;
			dll_busy_q <= 1'b0;
			dll_locked <= 1'b0;
		end else if (!devrst_s) begin
			dll_cnt_q <= '0;
			dll_busy_q <= 1'b0;
			dll_locked <= 1'b0;
		end else if (mrs_hit && ba[1:0] == 2'h0 && addr[MR_DLL_RST_BIT]) begin
			dll_cnt_q <= CNT_W'(TDLLK - 1);
			dll_busy_q <= 1'b1;
			dll_locked <= 1'b0;
		end else if (dll_busy_q && ck_rise && cke_s) begin
			if (dll_cnt_q == '0) begin
				dll_busy_q <= 1'b0;
				dll_locked <= 1'b1;
			end else begin
				dll_cnt_q <= dll_cnt_q - 1'b1;
			end
		end
	end

	// Long ZQ calibration timer.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			zq_cnt_q <= '0;
			zq_busy_q <= 1'b0;
			zq_done <= 1'b0;
		end else if (!devrst_s) begin
			zq_cnt_q <= '0;
			zq_busy_q <= 1'b0;
			zq_done <= 1'b0;
		end else if (zq_hit) begin
			zq_cnt_q <= CNT_W'(TZQINIT - 1);
			zq_busy_q <= 1'b1;
			zq_done <= 1'b0;
		end else if (zq_busy_q && ck_rise) begin
			if (zq_cnt_q == '0) begin
				zq_busy_q <= 1'b0;
				zq_done <= 1'b1;
			end else begin
				zq_cnt_q <= zq_cnt_q - 1'b1;
			end
		end
	end

	// Initialization progress as seen by the device.
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= DMS_RESET;
		end else if (!devrst_s) begin
			state_q <= DMS_RESET;
		end else begin
			unique case (state_q)
				DMS_RESET: state_q <= DMS_CKE_LOW;
				DMS_CKE_LOW: if (ck_rise && cke_s) state_q <= DMS_CKE_HIGH;
				DMS_CKE_HIGH: if (zq_hit) state_q <= DMS_CALIB;
				DMS_CALIB: if (dll_locked && zq_done) state_q <= DMS_READY;
				DMS_READY: if (zq_hit || (mrs_hit && ba[1:0] == 2'h0 && addr[MR_DLL_RST_BIT]))
					state_q <= DMS_CALIB;
				default: state_q <= DMS_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dev_ready <= 1'b0;
		end else begin
			dev_ready <= (state_q == DMS_CALIB || state_q == DMS_READY) && dll_locked && zq_done && devrst_s
				&& !zq_hit && !dll_rst_hit;
		end
	end
endmodule

// [verification/dms_ctl_model.sv]
// Controller model that drives the device pins.
`timescale 1ns/1ns
module dms_ctl_model
	import dms_pkg::*;
(
	input wire logic clk_sys,
	output logic ck,
	output logic dev_reset_n,
	output logic cke,
	output logic odt,
	output logic [CMD_W-1:0] cmd,
	output logic [BA_W-1:0] ba,
	output logic [MR_W-1:0] addr
);
	initial begin
		ck = 1'b0;
		dev_reset_n = 1'b0;
		cke = 1'b0;
		odt = 1'b0;
		cmd = CMD_NOP;
		ba = 3'h0;
		addr = 16'h0000;
		#1;
		forever begin
			#62 ck = 1'b1;
			#63 ck = 1'b0;
		end
	end
	task automatic start;
		repeat (20) @(posedge ck);
		@(posedge clk_sys);
		#1 dev_reset_n = 1'b1;
		repeat (10) @(posedge ck);
		@(posedge clk_sys);
		#1 odt = 1'b0;
		repeat (6) @(posedge ck);
		@(posedge clk_sys);
		#1 cke = 1'b1;
		repeat (10) @(posedge ck);
	endtask
	task automatic issue(input logic [CMD_W-1:0] c, input logic [BA_W-1:0] b, input logic [MR_W-1:0] a);
		@(negedge ck);
		@(posedge clk_sys);
		#1;
		cmd = c;
		ba = b;
		addr = a;
		@(posedge ck);
		repeat (8) @(posedge clk_sys);
		#1;
		cmd = CMD_NOP;
		addr = ~a;
	endtask
endmodule

// [verification/dms_top_properties.sv]
// Checker for the mode register and init tracker ports.
`timescale 1ns/1ns
module dms_top_properties
	import dms_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic dev_reset_n,
	input wire logic [MR_W-1:0] mr0,
	input wire logic term_enable,
	input wire logic features_valid,
	input wire logic dll_locked,
	input wire logic zq_done,
	input wire logic dev_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_term_off_reset: assert property (!dev_reset_n [*8] |-> !term_enable) else $error("term on in reset");
	a_ready_needs_both: assert property (dev_ready |-> dll_locked && zq_done) else $error("early ready");
	a_dll_bit_clear: assert property (mr0[MR_DLL_RST_BIT] == 1'b0) else $error("dll bit stuck");
	a_tmod_low_hold: assert property ($fell(features_valid) |=> !features_valid [*8]) else $error("short tmod");
	a_term_tmod_off: assert property (!features_valid |-> !term_enable) else $error("term in tmod");
	cover property (dev_ready);
	cover property ($fell(features_valid));
	cover property (term_enable);
	cover property ($fell(dev_ready));
endmodule
bind dms_top dms_top_properties chk_u (.clk_sys(clk_sys), .reset_n(reset_n), .dev_reset_n(dev_reset_n), .mr0(mr0),
	.term_enable(term_enable), .features_valid(features_valid), .dll_locked(dll_locked), .zq_done(zq_done),
	.dev_ready(dev_ready));

// [verification/dms_top_test.sv]
// Self-checking bench for the mode register and init tracker.
`timescale 1ns/1ns
module dms_top_test;
	import dms_pkg::*;
	typedef struct packed {logic [BA_W-1:0] b; logic [MR_W-1:0] a; logic [MR_W-1:0] e;} dms_row_type;
	logic clk_sys, reset_n, ck, dev_reset_n, cke, odt;
	logic [CMD_W-1:0] cmd;
	logic [BA_W-1:0] ba;
	logic [MR_W-1:0] addr, mr0, mr1, mr2, mr3;
	logic term_enable, features_valid, dll_locked, zq_done, dev_ready;
	logic [4*MR_W-1:0] mr_all;
	int bad_count = 0;
	int compares = 0;
	dms_row_type rows [4] = '{{3'h2, 16'h0018, 16'h0018}, {3'h3, 16'h0004, 16'h0004}, {3'h1, 16'h0044, 16'h0044},
		{3'h0, 16'h0D20, 16'h0C20}};
	assign mr_all = {mr3, mr2, mr1, mr0};
	dms_ctl_model ctl_u (.clk_sys(clk_sys), .ck(ck), .dev_reset_n(dev_reset_n), .cke(cke), .odt(odt), .cmd(cmd),
		.ba(ba), .addr(addr));
	dms_top #(.TMOD(4), .TDLLK(8), .TZQINIT(8)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .ck(ck),
		.dev_reset_n(dev_reset_n), .cke(cke), .odt(odt), .cmd(cmd), .ba(ba), .addr(addr), .mr0(mr0), .mr1(mr1),
		.mr2(mr2), .mr3(mr3), .term_enable(term_enable), .features_valid(features_valid), .dll_locked(dll_locked),
		.zq_done(zq_done), .dev_ready(dev_ready));
	task automatic check(input logic [4*MR_W-1:0] seen, input logic [4*MR_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_ready;
		for (int i = 0; i < 400 && dev_ready !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check(dev_ready, 1'b1);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		reset_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 reset_n = 1'b1;
		ctl_u.odt = 1'b1;
		repeat (40) @(posedge clk_sys);
		#1;
		check(term_enable, 1'b0);
		ctl_u.start();
		for (int i = 0; i < 4; i++) begin
			ctl_u.issue(CMD_MRS, rows[i].b, rows[i].a);
			check(features_valid, 1'b0);
			check(mr_all[rows[i].b[1:0]*MR_W +: MR_W], rows[i].e);
			repeat (60) @(posedge clk_sys);
			$display("row %0d done", i);
		end
		ctl_u.issue(CMD_ZQCL, 3'h0, 16'h0400);
		wait_ready();
		if (dev_ready === 1'b1) begin
			check({dll_locked, zq_done}, 2'h3);
			ctl_u.odt = 1'b1;
			repeat (20) @(posedge clk_sys);
			#1;
			check(term_enable, 1'b1);
			ctl_u.odt = 1'b0;
			repeat (20) @(posedge clk_sys);
			#1;
			ctl_u.issue(CMD_MRS, 3'h0, 16'h0D20);
			check(dev_ready, 1'b0);
			check(mr0, 16'h0C20);
			repeat (60) @(posedge clk_sys);
			#1;
			ctl_u.issue(CMD_ZQCL, 3'h0, 16'h0400);
			wait_ready();
			$display("relock test done");
			repeat (100) @(posedge clk_sys);
			#1;
			ctl_u.cke = 1'b0;
			ctl_u.issue(CMD_MRS, 3'h2, 16'h0000);
			repeat (10) @(posedge clk_sys);
			#1;
			check(mr2, 16'h0018);
			ctl_u.dev_reset_n = 1'b0;
			repeat (20) @(posedge clk_sys);
			#1;
			check(mr_all, 64'h0);
			check({term_enable, dev_ready}, 2'h0);
			ctl_u.dev_reset_n = 1'b1;
			repeat (20) @(posedge clk_sys);
			#1;
			ctl_u.cke = 1'b1;
			repeat (40) @(posedge clk_sys);
			#1;
			ctl_u.issue(CMD_MRS, 3'h1, 16'h0044);
			check(mr1, 16'h0044);
			reset_n = 1'b0;
			repeat (4) @(posedge clk_sys);
			#1;
			check({mr1, features_valid, dll_locked}, {16'h0000, 2'h2});
			reset_n = 1'b1;
			repeat (8) @(posedge clk_sys);
			#1;
			check({mr1, features_valid}, {16'h0000, 1'b1});
			$display("hand tests done");
		end
		close_out();
	end
endmodule
